/* File: src/opd_decoder.sv */
/*
 * first-byte and modrm decoder for a 16-bit instruction stream.
 * assumes fetch presents one byte per valid cycle, synchronous to
 * sys_clk_in; the datapath reads the registered result on dec_valid_out.
 */
// Notes on behaviour
// [RL1] byte FD sets direction flag, one byte
// [RL2] byte FB sets interrupt enable, one byte
// [RL3] 1010101w is store string, w sizes
// [RL4] subtract: 0010 10dw, grp1 reg 101, 0010 110w
// [RL5] xor: 0011 00dw, grp1 reg 110, 0011 010w
// [RL6] 1000010w test with modrm, flags only
// [RL7] test immediate: F6/F7 reg 000, A8/A9
// [RL8] 9B is coprocessor wait, pin dependent
// [RL9] D7 is table translate into low byte
// [RL10] lock stays active internally without pin
// [RL11] 26 prefix selects extra segment next
// [RL12] d picks destination, w picks width
// [RL13] exchange: 10010 reg, or 1000011w modrm
`timescale 1ns/10ps
`include "opd_defines.svh"

module opd_decoder (
    // clock and reset
    input  wire logic            sys_clk_in,
    input  wire logic            rst_n_in,
    // fetch side
    input  wire logic            byte_valid_in,
    input  wire logic [7:0]      byte_in,
    output logic                 byte_ready_out,
    // configuration
    input  wire logic            wait_pin_present_in,
    // datapath side
    output logic                 dec_valid_out,
    output opd_pkg::opd_op_t     dec_op_out,
    output logic [7:0]           dec_opcode_out,
    output logic [7:0]           dec_modrm_out,
    output logic                 dec_has_modrm_out,
    output logic                 dec_word_out,
    output logic                 dec_reg_is_dst_out,
    output logic                 dec_sign_ext_out,
    output opd_pkg::opd_imm_t    dec_imm_out,
    output logic                 dec_acc_form_out,
    output logic                 dec_writes_result_out,
    output logic [2:0]           dec_exchange_op_reg_out,
    output opd_pkg::opd_seg_t    dec_seg_out,
    output logic                 dec_lock_out,
    output logic                 dec_unsupported_out,
    output logic                 dec_invalid_out
);

    opd_pkg::opd_state_s_t st_r;
    opd_pkg::opd_state_s_t st_nxt;
    opd_pkg::opd_dec_t     first_dec;
    logic [2:0]            reg_fld;

    // ------------------------------------------------------------------
    // first byte classification
    // ------------------------------------------------------------------
    opd_first_byte u_first (
        .byte_in             (byte_in),
        .wait_pin_present_in (wait_pin_present_in),
        .dec_out             (first_dec)
    );

    assign reg_fld = byte_in[5:3];

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        st_nxt.valid = 1'b0;
        unique case (st_r.state)
            opd_pkg::OPD_ST_FIRST: begin
                if (byte_valid_in) begin
                    if (first_dec.op == opd_pkg::OPD_OP_PREFIX) begin
                        // prefixes accumulate until the opcode arrives
                        unique case (byte_in)
                            `OPD_PFX_EXTRA:
                                st_nxt.seg = opd_pkg::OPD_SEG_EXTRA; // [RL11]
                            `OPD_PFX_CODE:
                                st_nxt.seg = opd_pkg::OPD_SEG_CODE;
                            `OPD_PFX_STACK:
                                st_nxt.seg = opd_pkg::OPD_SEG_STACK;
                            `OPD_PFX_DATA:
                                st_nxt.seg = opd_pkg::OPD_SEG_DEFAULT;
                            default:
                                st_nxt.lock = 1'b1;  // [RL10]
                        endcase
                    end else if (first_dec.needs_modrm) begin
                        st_nxt.state  = opd_pkg::OPD_ST_MODRM;
                        st_nxt.pend   = first_dec;
                        st_nxt.opcode = byte_in;
                    end else begin
                        st_nxt.valid       = 1'b1;
                        st_nxt.out         = first_dec;
                        st_nxt.out_opcode  = byte_in;
                        st_nxt.modrm       = 8'h00;
                        st_nxt.out_invalid =
                            first_dec.op == opd_pkg::OPD_OP_UNKNOWN ||
                            first_dec.op == opd_pkg::OPD_OP_RESERVED;
                    end
                end
            end
            default: begin
                if (byte_valid_in) begin
                    st_nxt.state       = opd_pkg::OPD_ST_FIRST;
                    st_nxt.valid       = 1'b1;
                    st_nxt.out         = st_r.pend;
                    st_nxt.out_opcode  = st_r.opcode;
                    st_nxt.modrm       = byte_in;
                    st_nxt.out_invalid = 1'b0;
                    if ((st_r.opcode & `OPD_MASK_DW) == `OPD_GRP1_PAT) begin
                        unique case (reg_fld)
                            `OPD_REG_SUB:
                                st_nxt.out.op = opd_pkg::OPD_OP_SUB;  // [RL4]
                            `OPD_REG_XOR:
                                st_nxt.out.op = opd_pkg::OPD_OP_XOR;  // [RL5]
                            default: begin
                                // other group ops lie outside this block
                                st_nxt.out.op      = opd_pkg::OPD_OP_UNKNOWN;
                                st_nxt.out_invalid = 1'b1;
                            end
                        endcase
                        // sw=10 is not a legal encoding
                        if (st_r.opcode[1:0] == 2'b10) begin
                            st_nxt.out_invalid = 1'b1;
                        end
                    end else if ((st_r.opcode & `OPD_MASK_W) ==
                                 `OPD_TEST_IMM_PAT) begin
                        if (reg_fld == `OPD_REG_TEST) begin
                            st_nxt.out.op = opd_pkg::OPD_OP_TEST;  // [RL7]
                        end else begin
                            st_nxt.out.op      = opd_pkg::OPD_OP_UNKNOWN;
                            st_nxt.out_invalid = 1'b1;
                        end
                    end else if (st_r.pend.op == opd_pkg::OPD_OP_UNKNOWN) begin
                        st_nxt.out_invalid = 1'b1;
                    end
                end
            end
        endcase
        if (st_nxt.valid) begin
            st_nxt.out_seg  = st_r.seg;
            st_nxt.out_lock = st_r.lock;  // [RL10]
            st_nxt.seg      = opd_pkg::OPD_SEG_DEFAULT;
            st_nxt.lock     = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // no stall source inside the decoder; fetch is never held off
    assign byte_ready_out        = 1'b1;
    assign dec_valid_out         = st_r.valid;
    assign dec_op_out            = st_r.out.op;
    assign dec_opcode_out        = st_r.out_opcode;
    assign dec_modrm_out         = st_r.modrm;
    assign dec_has_modrm_out     = st_r.out.needs_modrm;
    assign dec_word_out          = st_r.out.word;
    assign dec_reg_is_dst_out    = st_r.out.reg_is_dst;
    assign dec_sign_ext_out      = st_r.out.sign_ext;
    assign dec_imm_out           = st_r.out.imm;
    assign dec_acc_form_out      = st_r.out.acc_form;
    assign dec_writes_result_out = st_r.out.writes_result;
    assign dec_exchange_op_reg_out      = st_r.out_opcode[2:0];  // [RL13]
    assign dec_seg_out           = st_r.out_seg;
    assign dec_lock_out          = st_r.out_lock;
    assign dec_unsupported_out   = st_r.out.unsupported;
    assign dec_invalid_out       = st_r.out_invalid;

endmodule

/* File: src/opd_defines.svh */
/*
 * opcode decoder constants: opcode values, masks, field positions.
 * assumes inclusion by bare name from any decoder file.
 */
`ifndef OPD_DEFINES_SVH
`define OPD_DEFINES_SVH

// ----------------------------------------------------------------------
// single-byte opcodes
// ----------------------------------------------------------------------
`define OPD_SET_DIR          8'hFD
`define OPD_SET_IEN          8'hFB
`define OPD_WAIT_COP         8'h9B
`define OPD_TABLE_TRANSLATE_OP_BYTE        8'hD7
`define OPD_PFX_EXTRA        8'h26
`define OPD_PFX_CODE         8'h2E
`define OPD_PFX_STACK        8'h36
`define OPD_PFX_DATA         8'h3E
`define OPD_LOCK_PFX         8'hF0

// ----------------------------------------------------------------------
// patterns with low bits masked
// ----------------------------------------------------------------------
`define OPD_MASK_W           8'hFE
`define OPD_MASK_DW          8'hFC
`define OPD_MASK_REG3        8'hF8
`define OPD_STORE_STRING_OP_PAT         8'hAA
`define OPD_SUB_RM_PAT       8'h28
`define OPD_SUB_ACC_PAT      8'h2C
`define OPD_XOR_RM_PAT       8'h30
`define OPD_XOR_ACC_PAT      8'h34
`define OPD_GRP1_PAT         8'h80
`define OPD_TEST_RM_PAT      8'h84
`define OPD_TEST_IMM_PAT     8'hF6
`define OPD_TEST_ACC_PAT     8'hA8
`define OPD_EXCHANGE_OP_RM_PAT      8'h86
`define OPD_EXCHANGE_OP_ACC_PAT     8'h90
`define OPD_LOW_LAST         8'h29

// ----------------------------------------------------------------------
// field positions and reg-field codes
// ----------------------------------------------------------------------
`define OPD_W_BIT            0
`define OPD_D_BIT            1
`define OPD_S_BIT            1
`define OPD_REG_SUB          3'h5
`define OPD_REG_XOR          3'h6
`define OPD_REG_TEST         3'h0

`endif

/* File: src/opd_first_byte.sv */
/*
 * combinational classification of one first opcode byte.
 * assumes the byte is a fetched first byte, not modrm or data.
 */
`timescale 1ns/10ps
`include "opd_defines.svh"

module opd_first_byte (
    // byte to classify
    input  wire logic [7:0]      byte_in,
    input  wire logic            wait_pin_present_in,
    // decoded attributes
    output opd_pkg::opd_dec_t    dec_out
);

    logic w;
    logic d;
    opd_pkg::opd_imm_t imm_w;

    assign w = byte_in[`OPD_W_BIT];
    assign d = byte_in[`OPD_D_BIT];
    assign imm_w = w ? opd_pkg::OPD_IMM_WORD : opd_pkg::OPD_IMM_BYTE;

    always_comb begin
        dec_out               = '0;
        dec_out.op            = opd_pkg::OPD_OP_UNKNOWN;
        dec_out.imm           = opd_pkg::OPD_IMM_NONE;
        dec_out.word          = w;
        dec_out.writes_result = 1'b1;
        if (byte_in == `OPD_SET_DIR) begin
            dec_out.op   = opd_pkg::OPD_OP_SET_DIR;  // [RL1]
            dec_out.word = 1'b0;
        end else if (byte_in == `OPD_SET_IEN) begin
            dec_out.op   = opd_pkg::OPD_OP_SET_IEN;  // [RL2]
            dec_out.word = 1'b0;
        end else if (byte_in == `OPD_WAIT_COP) begin
            dec_out.op          = opd_pkg::OPD_OP_WAIT;  // [RL8]
            dec_out.word        = 1'b0;
            dec_out.unsupported = !wait_pin_present_in;  // [RL8]
        end else if (byte_in == `OPD_TABLE_TRANSLATE_OP_BYTE) begin
            dec_out.op   = opd_pkg::OPD_OP_TABLE_TRANSLATE_OP;  // [RL9]
            dec_out.word = 1'b0;
        end else if ((byte_in & `OPD_MASK_W) == `OPD_STORE_STRING_OP_PAT) begin
            dec_out.op = opd_pkg::OPD_OP_STORE_STRING_OP;  // [RL3]
        end else if ((byte_in & `OPD_MASK_W) == `OPD_SUB_ACC_PAT) begin
            dec_out.op       = opd_pkg::OPD_OP_SUB;  // [RL4]
            dec_out.acc_form = 1'b1;
            dec_out.imm      = imm_w;
        end else if ((byte_in & `OPD_MASK_W) == `OPD_XOR_ACC_PAT) begin
            dec_out.op       = opd_pkg::OPD_OP_XOR;  // [RL5]
            dec_out.acc_form = 1'b1;
            dec_out.imm      = imm_w;
        end else if ((byte_in & `OPD_MASK_W) == `OPD_TEST_ACC_PAT) begin
            dec_out.op            = opd_pkg::OPD_OP_TEST;  // [RL7]
            dec_out.acc_form      = 1'b1;
            dec_out.writes_result = 1'b0;
            dec_out.imm           = imm_w;
        end else if ((byte_in & `OPD_MASK_W) == `OPD_TEST_RM_PAT) begin
            dec_out.op            = opd_pkg::OPD_OP_TEST;  // [RL6]
            dec_out.needs_modrm   = 1'b1;
            dec_out.writes_result = 1'b0;  // [RL6]
        end else if ((byte_in & `OPD_MASK_W) == `OPD_EXCHANGE_OP_RM_PAT) begin
            dec_out.op          = opd_pkg::OPD_OP_EXCHANGE_OP;  // [RL13]
            dec_out.needs_modrm = 1'b1;
        end else if ((byte_in & `OPD_MASK_REG3) == `OPD_EXCHANGE_OP_ACC_PAT) begin
            dec_out.op       = opd_pkg::OPD_OP_EXCHANGE_OP;  // [RL13]
            dec_out.word     = 1'b1;
            dec_out.acc_form = 1'b1;
        end else if ((byte_in & `OPD_MASK_DW) == `OPD_GRP1_PAT) begin
            // operation comes from the reg field of the second byte
            dec_out.op          = opd_pkg::OPD_OP_NONE;
            dec_out.needs_modrm = 1'b1;
            dec_out.sign_ext    = byte_in[`OPD_S_BIT];
            dec_out.imm         = (byte_in[1:0] == 2'b01)
                                  ? opd_pkg::OPD_IMM_WORD
                                  : opd_pkg::OPD_IMM_BYTE;
        end else if ((byte_in & `OPD_MASK_W) == `OPD_TEST_IMM_PAT) begin
            // only reg field 000 is the immediate test
            dec_out.op            = opd_pkg::OPD_OP_NONE;
            dec_out.needs_modrm   = 1'b1;
            dec_out.writes_result = 1'b0;
            dec_out.imm           = imm_w;
        end else if (byte_in == `OPD_PFX_EXTRA ||
                     byte_in == `OPD_PFX_CODE ||
                     byte_in == `OPD_PFX_STACK ||
                     byte_in == `OPD_PFX_DATA ||
                     byte_in == `OPD_LOCK_PFX) begin
            dec_out.op   = opd_pkg::OPD_OP_PREFIX;  // [RL11]
            dec_out.word = 1'b0;
        end else if (byte_in <= `OPD_LOW_LAST ||
                     (byte_in & `OPD_MASK_DW) == `OPD_SUB_RM_PAT ||
                     (byte_in & `OPD_MASK_DW) == `OPD_XOR_RM_PAT) begin
            // low range: groups of eight, low three bits pick the form
            dec_out.word = w;  // [RL12]
            unique case (byte_in[5:3])
                3'd0: dec_out.op = opd_pkg::OPD_OP_ADD;
                3'd1: dec_out.op = opd_pkg::OPD_OP_OR;
                3'd2: dec_out.op = opd_pkg::OPD_OP_ADC;
                3'd3: dec_out.op = opd_pkg::OPD_OP_SBB;
                3'd4: dec_out.op = opd_pkg::OPD_OP_AND;
                3'd5: dec_out.op = opd_pkg::OPD_OP_SUB;  // [RL4]
                3'd6: dec_out.op = opd_pkg::OPD_OP_XOR;  // [RL5]
                default: dec_out.op = opd_pkg::OPD_OP_UNKNOWN;
            endcase
            unique case (byte_in[2:0])
                3'd0, 3'd1, 3'd2, 3'd3: begin
                    dec_out.needs_modrm = 1'b1;
                    dec_out.reg_is_dst  = d;  // [RL12]
                end
                3'd4, 3'd5: begin
                    dec_out.acc_form = 1'b1;
                    dec_out.imm      = imm_w;
                end
                3'd6: begin
                    dec_out.op   = opd_pkg::OPD_OP_PUSH_SEG;
                    dec_out.word = 1'b1;
                end
                default: begin
                    dec_out.word = 1'b1;
                    if (byte_in == 8'h0F) begin
                        dec_out.op = opd_pkg::OPD_OP_RESERVED;
                    end else if (byte_in == 8'h27) begin
                        dec_out.op   = opd_pkg::OPD_OP_DECADJ;
                        dec_out.word = 1'b0;
                    end else begin
                        dec_out.op = opd_pkg::OPD_OP_POP_SEG;
                    end
                end
            endcase
        end
    end

endmodule

/* File: src/opd_pkg.sv */
/*
 * opcode decoder types.
 * assumes opd_defines.svh is available to users of these types.
 */
package opd_pkg;

    typedef enum logic [4:0] {
        OPD_OP_NONE,
        OPD_OP_ADD,
        OPD_OP_OR,
        OPD_OP_ADC,
        OPD_OP_SBB,
        OPD_OP_AND,
        OPD_OP_SUB,
        OPD_OP_XOR,
        OPD_OP_TEST,
        OPD_OP_EXCHANGE_OP,
        OPD_OP_STORE_STRING_OP,
        OPD_OP_TABLE_TRANSLATE_OP,
        OPD_OP_SET_DIR,
        OPD_OP_SET_IEN,
        OPD_OP_WAIT,
        OPD_OP_PUSH_SEG,
        OPD_OP_POP_SEG,
        OPD_OP_DECADJ,
        OPD_OP_PREFIX,
        OPD_OP_RESERVED,
        OPD_OP_UNKNOWN
    } opd_op_t;

    typedef enum logic [1:0] {
        OPD_SEG_DEFAULT,
        OPD_SEG_EXTRA,
        OPD_SEG_CODE,
        OPD_SEG_STACK
    } opd_seg_t;

    typedef enum logic [1:0] {
        OPD_IMM_NONE,
        OPD_IMM_BYTE,
        OPD_IMM_WORD
    } opd_imm_t;

    typedef enum logic [1:0] {
        OPD_ST_FIRST,
        OPD_ST_MODRM
    } opd_state_t;

    typedef struct packed {
        opd_op_t  op;
        logic     needs_modrm;
        logic     word;
        logic     reg_is_dst;
        logic     sign_ext;
        opd_imm_t imm;
        logic     acc_form;
        logic     writes_result;
        logic     unsupported;
    } opd_dec_t;

    typedef struct packed {
        opd_state_t state;
        opd_dec_t   pend;
        logic [7:0] opcode;
        opd_seg_t   seg;
        logic       lock;
        logic       valid;
        opd_dec_t   out;
        logic [7:0] out_opcode;
        logic [7:0] modrm;
        opd_seg_t   out_seg;
        logic       out_lock;
        logic       out_invalid;
    } opd_state_s_t;

endpackage

/* File: testbench/opd_decoder_properties.sv */
/*
 * concurrent checks on the opcode decoder ports.
 * assumes binding to opd_decoder, one clock, async low reset.
 */
`timescale 1ns/10ps

module opd_decoder_checker (
    // clock and reset
    input wire logic              sys_clk_in,
    input wire logic              rst_n_in,
    // fetch side
    input wire logic [7:0]        byte_in,
    input wire logic              wait_pin_present_in,
    // datapath side
    input wire logic              dec_valid_out,
    input wire opd_pkg::opd_op_t  dec_op_out,
    input wire logic [7:0]        dec_opcode_out,
    input wire logic [7:0]        dec_modrm_out,
    input wire logic              dec_has_modrm_out,
    input wire logic              dec_word_out,
    input wire logic              dec_reg_is_dst_out,
    input wire opd_pkg::opd_imm_t dec_imm_out,
    input wire logic              dec_acc_form_out,
    input wire logic              dec_writes_result_out,
    input wire logic [2:0]        dec_exchange_op_reg_out,
    input wire opd_pkg::opd_seg_t dec_seg_out,
    input wire logic              dec_unsupported_out
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_set_dir_byte: assert property (
        dec_valid_out && dec_op_out == opd_pkg::OPD_OP_SET_DIR
        |-> $past(byte_in) == 8'hFD && !dec_has_modrm_out)
        else $error("set direction from wrong byte");
    a_set_ien_byte: assert property (
        dec_valid_out && dec_op_out == opd_pkg::OPD_OP_SET_IEN
        |-> $past(byte_in) == 8'hFB && !dec_has_modrm_out)
        else $error("set interrupt enable from wrong byte");
    a_store_string_op_width: assert property (
        dec_valid_out && dec_op_out == opd_pkg::OPD_OP_STORE_STRING_OP
        |-> $past(byte_in[7:1]) == 7'h55
            && dec_word_out == $past(byte_in[0]))
        else $error("store string width wrong");
    a_sub_grp_reg: assert property (
        dec_valid_out && dec_op_out == opd_pkg::OPD_OP_SUB
        && dec_opcode_out[7:2] == 6'h20
        |-> dec_modrm_out[5:3] == 3'h5 && $past(byte_in) == dec_modrm_out)
        else $error("group subtract reg field wrong");
    a_test_no_result: assert property (
        dec_valid_out && dec_op_out == opd_pkg::OPD_OP_TEST
        |-> !dec_writes_result_out)
        else $error("test writes a result");
    a_test_acc_imm: assert property (
        dec_valid_out && dec_opcode_out[7:1] == 7'h54
        |-> dec_acc_form_out && dec_imm_out == (dec_opcode_out[0] ?
            opd_pkg::OPD_IMM_WORD : opd_pkg::OPD_IMM_BYTE))
        else $error("accumulator test immediate length wrong");
    a_wait_pin_dep: assert property (
        dec_valid_out && dec_op_out == opd_pkg::OPD_OP_WAIT
        |-> dec_unsupported_out == !$past(wait_pin_present_in))
        else $error("wait support flag wrong");
    a_table_translate_op_byte: assert property (
        dec_valid_out && dec_op_out == opd_pkg::OPD_OP_TABLE_TRANSLATE_OP
        |-> $past(byte_in) == 8'hD7)
        else $error("translate from wrong byte");
    a_low_dw_bits: assert property (
        dec_valid_out && dec_opcode_out <= 8'h29 && dec_has_modrm_out
        |-> dec_word_out == dec_opcode_out[0]
            && dec_reg_is_dst_out == dec_opcode_out[1])
        else $error("low range d or w wrong");
    a_exchange_op_acc_reg: assert property (
        dec_valid_out && dec_opcode_out[7:3] == 5'h12
        |-> dec_op_out == opd_pkg::OPD_OP_EXCHANGE_OP
            && dec_exchange_op_reg_out == dec_opcode_out[2:0])
        else $error("exchange register wrong");

    c_set_dir: cover property (dec_valid_out
        && dec_op_out == opd_pkg::OPD_OP_SET_DIR);
    c_test_extra: cover property (dec_valid_out
        && dec_op_out == opd_pkg::OPD_OP_TEST
        && dec_seg_out == opd_pkg::OPD_SEG_EXTRA);
    c_wait_unsup: cover property (dec_valid_out && dec_unsupported_out);
endmodule

bind opd_decoder opd_decoder_checker u_opd_decoder_checker (.*);

/* File: testbench/opd_fetch_model.sv */
/*
 * fetch unit model: presents queued bytes one per cycle.
 * assumes the bench pushes bytes between clock edges.
 */
`timescale 1ns/10ps

module opd_fetch_model (
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    // byte stream
    output logic            byte_valid_out,
    output logic [7:0]      byte_out
);
    logic [7:0] queue_r[$];

    task automatic push(input logic [7:0] b);
        queue_r.push_back(b);
    endtask

    // idle bus inverts the held byte every cycle, so stale bytes never look valid
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            byte_valid_out <= 1'b0;
            byte_out       <= 8'h00;
        end else if (queue_r.size() > 0) begin
            byte_valid_out <= 1'b1;
            byte_out       <= queue_r.pop_front();
        end else begin
            byte_valid_out <= 1'b0;
            byte_out       <= ~byte_out;
        end
    end
endmodule

/* File: testbench/test_opd_decoder.sv */
/*
 * self-checking bench for the opcode decoder.
 * assumes the fetch model feeds bytes; datapath side observed here.
 */
`timescale 1ns/10ps

module test_opd_decoder;
    logic sys_clk_in = 1'b0;
    logic rst_n_in   = 1'b0;
    logic wait_pin   = 1'b1;
    logic bv;
    logic [7:0] bd, opc, mrm;
    logic rdy, vld, hm, wd, dst, sx, acc, wr, lk, un, inv;
    logic [2:0] xr;
    opd_pkg::opd_op_t  op;
    opd_pkg::opd_imm_t imm;
    opd_pkg::opd_seg_t seg;
    int fail_count = 0;
    int cmp_count  = 0;
    int cycles     = 0;

    initial forever #2.5 sys_clk_in = ~sys_clk_in;

    opd_fetch_model u_opd_fetch_model (.sys_clk_in, .rst_n_in,
        .byte_valid_out(bv), .byte_out(bd));

    opd_decoder u_opd_decoder (.sys_clk_in,
        .rst_n_in, .byte_valid_in(bv), .byte_in(bd),
        .byte_ready_out(rdy), .wait_pin_present_in(wait_pin),
        .dec_valid_out(vld), .dec_op_out(op), .dec_opcode_out(opc),
        .dec_modrm_out(mrm), .dec_has_modrm_out(hm),
        .dec_word_out(wd), .dec_reg_is_dst_out(dst),
        .dec_sign_ext_out(sx), .dec_imm_out(imm),
        .dec_acc_form_out(acc), .dec_writes_result_out(wr),
        .dec_exchange_op_reg_out(xr), .dec_seg_out(seg), .dec_lock_out(lk),
        .dec_unsupported_out(un), .dec_invalid_out(inv));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic ck(input string n, input logic [7:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    // one instruction of n bytes, then wait for its decode
    task automatic send(input opd_pkg::opd_op_t e, input int n,
                        input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00);
        int i = 0;
        u_opd_fetch_model.push(b0);
        if (n > 1) u_opd_fetch_model.push(b1);
        if (n > 2) u_opd_fetch_model.push(b2);
        do begin
            @(posedge sys_clk_in) #1;
            i++;
        end while (vld !== 1'b1 && i < 20);
        ck("valid", 8'(vld), 8'h01);
        ck("op", 8'(op), 8'(e));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_single();
        send(opd_pkg::OPD_OP_SET_DIR, 1, 8'hFD);
        ck("modrm", 8'(hm), 8'h00);
        send(opd_pkg::OPD_OP_SET_IEN, 1, 8'hFB);
        send(opd_pkg::OPD_OP_STORE_STRING_OP, 1, 8'hAB);
        ck("word", 8'(wd), 8'h01);
        send(opd_pkg::OPD_OP_STORE_STRING_OP, 1, 8'hAA);
        ck("word", 8'(wd), 8'h00);
        send(opd_pkg::OPD_OP_TABLE_TRANSLATE_OP, 1, 8'hD7);
        @(posedge sys_clk_in) wait_pin <= 1'b0;
        send(opd_pkg::OPD_OP_WAIT, 1, 8'h9B);
        ck("unsup", 8'(un), 8'h01);
        @(posedge sys_clk_in) wait_pin <= 1'b1;
        send(opd_pkg::OPD_OP_WAIT, 1, 8'h9B);
        ck("unsup", 8'(un), 8'h00);
    endtask

    task automatic t_b2b();
        u_opd_fetch_model.push(8'hFD);
        send(opd_pkg::OPD_OP_SET_DIR, 1, 8'hFB);
        @(posedge sys_clk_in) #1;
        ck("valid2", 8'(vld), 8'h01);
        ck("op2", 8'(op), 8'(opd_pkg::OPD_OP_SET_IEN));
    endtask

    task automatic t_sub_xor();
        send(opd_pkg::OPD_OP_SUB, 2, 8'h28, 8'hC1);
        ck("dst", 8'({dst, wd}), 8'h00);
        ck("mrm", mrm, 8'hC1);
        send(opd_pkg::OPD_OP_SUB, 2, 8'h2B, 8'hC1);
        ck("dst", 8'({dst, wd}), 8'h03);
        send(opd_pkg::OPD_OP_SUB, 2, 8'h81, 8'hE8);
        ck("imm", 8'(imm), 8'(opd_pkg::OPD_IMM_WORD));
        send(opd_pkg::OPD_OP_SUB, 2, 8'h83, 8'hE8);
        ck("sx", 8'({sx, imm}), 8'h04 | 8'(opd_pkg::OPD_IMM_BYTE));
        send(opd_pkg::OPD_OP_SUB, 1, 8'h2D);
        ck("acc", 8'({acc, imm}), 8'h04 | 8'(opd_pkg::OPD_IMM_WORD));
        send(opd_pkg::OPD_OP_XOR, 2, 8'h31, 8'hC0);
        ck("wd", 8'(wd), 8'h01);
        send(opd_pkg::OPD_OP_XOR, 2, 8'h80, 8'hF0);
        send(opd_pkg::OPD_OP_XOR, 1, 8'h34);
        ck("imm", 8'(imm), 8'(opd_pkg::OPD_IMM_BYTE));
    endtask

    task automatic t_test_seg();
        send(opd_pkg::OPD_OP_TEST, 2, 8'h85, 8'hC0);
        ck("wr", 8'(wr), 8'h00);
        send(opd_pkg::OPD_OP_TEST, 3, 8'h26, 8'hF7, 8'hC0);
        ck("imm", 8'(imm), 8'(opd_pkg::OPD_IMM_WORD));
        ck("seg", 8'(seg), 8'(opd_pkg::OPD_SEG_EXTRA));
        send(opd_pkg::OPD_OP_TEST, 1, 8'hA8);
        ck("seg", 8'(seg), 8'(opd_pkg::OPD_SEG_DEFAULT));
        send(opd_pkg::OPD_OP_UNKNOWN, 2, 8'hF6, 8'hC8);
        send(opd_pkg::OPD_OP_STORE_STRING_OP, 3, 8'h26, 8'h3E, 8'hAA);
        ck("seg", 8'(seg), 8'(opd_pkg::OPD_SEG_DEFAULT));
    endtask

    task automatic t_exchange_op_lock();
        send(opd_pkg::OPD_OP_EXCHANGE_OP, 1, 8'h93);
        ck("xreg", 8'(xr), 8'h03);
        send(opd_pkg::OPD_OP_EXCHANGE_OP, 3, 8'hF0, 8'h87, 8'hC0);
        ck("lock", 8'({lk, hm}), 8'h03);
        send(opd_pkg::OPD_OP_EXCHANGE_OP, 1, 8'h90);
        ck("lock", 8'(lk), 8'h00);
    endtask

    // ------------------------------------------------------------
    // main sequence and timeout
    // ------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles >= 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge sys_clk_in);
        ck("ready", 8'(rdy), 8'h01);
        ck("valid", 8'(vld), 8'h00);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        t_single();
        t_b2b();
        t_sub_xor();
        t_test_seg();
        t_exchange_op_lock();
        repeat (4) @(posedge sys_clk_in);
        print_verdict();
    end
endmodule
